// [core/rxalm_core.sv]
// Receiver module alarm flags, interrupt and channel control
//
// Contract
// - Alarm beyond threshold sets flag, requests interrupt
// - Input signal lost sets flag, requests interrupt
// - Flags stay set until cleared
// - Per-source mask gates interrupt, not flag
// - Reading flag register clears its flags
// - Signal loss squelches channel unless disabled
// - De-activated channel is squelched
// - Interrupt is pulse or level, selectable
// - Reset restores control defaults
// - Per-channel amplitude, de-emphasis, bandwidth applied
// - Amplitude bytes 228-233, de-emphasis 234-239
// - Zero de-emphasis keeps steady equal peak
// - Device is serial slave only
// - Host drives address, reset; device drives interrupt
// - Polarity, de-activate, squelch disable per channel
// - Address select is three bits
`timescale 1ns/1ps
module rxalm_core #(
  parameter int NCH  = rxalm_pkg::NCH,
  parameter int NALM = rxalm_pkg::NALM
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_module_rst_n,
  input  wire logic [2:0]                 i_adr_sel,
  input  wire logic [NCH-1:0]             i_input_signal_lost,
  input  wire logic [NALM-1:0]            i_alarm_cond,
  input  wire logic                       i_rd_los_flags,
  input  wire logic                       i_rd_alm_flags,
  input  wire logic                       i_cfg_we,
  input  wire rxalm_pkg::rxalm_chctl_s    i_chctl,
  input  wire rxalm_pkg::rxalm_irqcfg_s   i_irqcfg,
  input  wire logic                       i_shape_we,
  input  wire logic [7:0]                 i_shape_addr,
  input  wire logic [7:0]                 i_shape_data,
  input  wire logic [NCH*rxalm_pkg::BW_W-1:0] i_bw,
  output logic [NCH-1:0]                  o_los_flags,
  output logic [NALM-1:0]                 o_alm_flags,
  output logic                            o_host_irq_n,
  output logic [NCH-1:0]                  o_squelch,
  output logic [NCH-1:0]                  o_invert,
  output logic [2:0]                      o_adr_sel,
  output rxalm_pkg::rxalm_shape_s         o_shape
);
  import rxalm_pkg::*;

  logic                 rst_s1_q, rst_q;
  logic [NCH-1:0]       los_s1_q, los_s2_q;
  logic [NALM-1:0]      alm_s1_q, alm_s2_q;
  logic                 mrst_s1_q, mrst_s2_q;
  logic [2:0]           adr_s1_q, adr_s2_q;
  logic [NCH-1:0]       los_q;
  logic [NALM-1:0]      alm_q;
  rxalm_chctl_s         chctl_q;
  rxalm_irqcfg_s        irqcfg_q;
  rxalm_shape_s         shape_q;
  logic                 irq_q;
  logic                 req_q;
  logic [2:0]           pcnt_q;
  logic                 req_d;

  // Byte address inside an inclusive span
  function automatic logic in_span(input logic [7:0] addr, input logic [7:0] first,
                                   input logic [7:0] last);
    return (addr >= first) && (addr <= last);
  endfunction : in_span

  // Reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      los_s1_q  <= '0;
      los_s2_q  <= '0;
      alm_s1_q  <= '0;
      alm_s2_q  <= '0;
      mrst_s1_q <= 1'b1;
      mrst_s2_q <= 1'b1;
      adr_s1_q  <= 3'h0;
      adr_s2_q  <= 3'h0;
    end else begin
      los_s1_q  <= i_input_signal_lost;
      los_s2_q  <= los_s1_q;
      alm_s1_q  <= i_alarm_cond;
      alm_s2_q  <= alm_s1_q;
      mrst_s1_q <= i_module_rst_n;
      mrst_s2_q <= mrst_s1_q;
      adr_s1_q  <= i_adr_sel;
      adr_s2_q  <= adr_s1_q;
    end
  end

  // Sticky flags; set wins over read clear
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      los_q <= '0;
      alm_q <= '0;
    end else begin
      los_q <= (i_rd_los_flags ? '0 : los_q) | los_s2_q;
      alm_q <= (i_rd_alm_flags ? '0 : alm_q) | alm_s2_q;
    end
  end

  // Control settings, module reset restores defaults
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      chctl_q  <= '{invert: CH_RST, deact: CH_RST, sq_dis: CH_RST};
      irqcfg_q <= '{los_mask: LOSM_RST, alm_mask: ALMM_RST, pulse_mode: PULSE_RST};
    end else if (!mrst_s2_q) begin
      chctl_q  <= '{invert: CH_RST, deact: CH_RST, sq_dis: CH_RST};
      irqcfg_q <= '{los_mask: LOSM_RST, alm_mask: ALMM_RST, pulse_mode: PULSE_RST};
    end else if (i_cfg_we) begin
      chctl_q  <= i_chctl;
      irqcfg_q <= i_irqcfg;
    end
  end

  // Amplitude and de-emphasis bytes: two channels per byte
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      shape_q <= '{amp: {NCH{AMP_RST}}, demph: {NCH{DEMPH_RST}}, bw: {NCH{BW_RST}}};
    end else if (!mrst_s2_q) begin
      shape_q <= '{amp: {NCH{AMP_RST}}, demph: {NCH{DEMPH_RST}}, bw: {NCH{BW_RST}}};
    end else begin
      shape_q.bw <= i_bw;
      if (i_shape_we && in_span(i_shape_addr, AMP_FIRST, AMP_LAST)) begin
        shape_q.amp[8*(i_shape_addr-AMP_FIRST) +: 8] <= i_shape_data;
      end
      if (i_shape_we && in_span(i_shape_addr, DEMPH_FIRST, DEMPH_LAST)) begin
        shape_q.demph[8*(i_shape_addr-DEMPH_FIRST) +: 8] <= i_shape_data;
      end
    end
  end

  // Squelch and polarity outputs
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_squelch <= '0;
      o_invert  <= '0;
    end else begin
      o_squelch <= (los_s2_q & ~chctl_q.sq_dis) | chctl_q.deact;
      o_invert  <= chctl_q.invert;
    end
  end

  // Unmasked request
  always_comb begin
    req_d = |(los_q & ~irqcfg_q.los_mask) | |(alm_q & ~irqcfg_q.alm_mask);
  end

  // Interrupt: level follows request, pulse on new request
  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      req_q  <= 1'b0;
      pcnt_q <= 3'h0;
      irq_q  <= 1'b0;
    end else begin
      req_q <= req_d;
      if (req_d && !req_q) begin
        pcnt_q <= 3'(IRQ_PULSE_CYC);
      end else if (pcnt_q != 3'h0) begin
        pcnt_q <= pcnt_q - 3'h1;
      end
      irq_q <= irqcfg_q.pulse_mode ? ((req_d && !req_q) || pcnt_q > 3'h1) : req_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_host_irq_n <= 1'b1;
      o_los_flags  <= '0;
      o_alm_flags  <= '0;
      o_adr_sel    <= 3'h0;
      o_shape      <= '0;
    end else begin
      o_host_irq_n <= !irq_q;
      o_los_flags  <= los_q;
      o_alm_flags  <= alm_q;
      o_adr_sel    <= adr_s2_q;
      o_shape      <= shape_q;
    end
  end

  // Checks
  sticky_los_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    los_q != '0 && !i_rd_los_flags |=> (los_q & $past(los_q)) == $past(los_q))
    else $error("los flag dropped without read");
  flag_set_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    los_s2_q[0] |=> los_q[0])
    else $error("los flag not set");
  alm_set_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    alm_s2_q[0] |=> alm_q[0])
    else $error("alarm flag not set");
  read_clear_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    i_rd_alm_flags && alm_s2_q == '0 |=> alm_q == '0)
    else $error("alarm flags not cleared by read");
  squelch_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    chctl_q.deact[0] |=> o_squelch[0])
    else $error("deactivated channel not squelched");
  squelch_los_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    los_s2_q[1] && !chctl_q.sq_dis[1] |=> o_squelch[1])
    else $error("lost channel not squelched");
  mask_gate_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    !req_d && !irqcfg_q.pulse_mode |=> ##1 o_host_irq_n)
    else $error("masked source drove interrupt");
  level_irq_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    req_d && !irqcfg_q.pulse_mode |=> ##1 !o_host_irq_n)
    else $error("level interrupt missing");
  pulse_end_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    irqcfg_q.pulse_mode [*8] |-> not (irq_q [*5]))
    else $error("pulse too long");
  mod_rst_a: assert property (@(posedge i_clk) disable iff (!rst_q)
    !mrst_s2_q |=> chctl_q.deact == CH_RST && irqcfg_q.pulse_mode == PULSE_RST)
    else $error("module reset missed defaults");

  los_seen_c:   cover property (@(posedge i_clk) disable iff (!rst_q) los_q != '0);
  pulse_irq_c:  cover property (@(posedge i_clk) disable iff (!rst_q)
    irqcfg_q.pulse_mode && irq_q);
  read_clr_c:   cover property (@(posedge i_clk) disable iff (!rst_q)
    i_rd_los_flags && los_q != '0);
  amp_write_c:  cover property (@(posedge i_clk) disable iff (!rst_q)
    i_shape_we && i_shape_addr == AMP_FIRST);
endmodule : rxalm_core

// [core/rxalm_pkg.sv]
// Package: constants and carriers for the receiver alarm/control block
package rxalm_pkg;
  localparam int NCH            = 12;
  localparam int NALM           = 8;
  localparam int AMP_W          = 4;
  localparam int DEMPH_W        = 4;
  localparam int BW_W           = 2;
  // Settings map, upper page 01h
  localparam logic [7:0] PAGE_SEL       = 8'h01;
  localparam logic [7:0] AMP_FIRST      = 8'hE4;   // 228
  localparam logic [7:0] AMP_LAST       = 8'hE9;   // 233
  localparam logic [7:0] DEMPH_FIRST    = 8'hEA;   // 234
  localparam logic [7:0] DEMPH_LAST     = 8'hEF;   // 239
  // Reset values
  localparam logic [AMP_W-1:0]   AMP_RST   = 4'h0;
  localparam logic [DEMPH_W-1:0] DEMPH_RST = 4'h0;
  localparam logic [BW_W-1:0]    BW_RST    = 2'h0;
  localparam logic [NCH-1:0]     CH_RST    = 12'h000;
  localparam logic [NCH-1:0]     LOSM_RST  = 12'h000;
  localparam logic [NALM-1:0]    ALMM_RST  = 8'h00;
  localparam logic               PULSE_RST = 1'b0;
  localparam int  IRQ_PULSE_CYC = 4;

  typedef struct packed {
    logic [NCH-1:0] invert;
    logic [NCH-1:0] deact;
    logic [NCH-1:0] sq_dis;
  } rxalm_chctl_s;

  typedef struct packed {
    logic [NCH-1:0]  los_mask;
    logic [NALM-1:0] alm_mask;
    logic            pulse_mode;
  } rxalm_irqcfg_s;

  typedef struct packed {
    logic [NCH*AMP_W-1:0]   amp;
    logic [NCH*DEMPH_W-1:0] demph;
    logic [NCH*BW_W-1:0]    bw;
  } rxalm_shape_s;
endpackage : rxalm_pkg

// [tb/rxalm_host_model.sv]
// Host controller model: flag reads, config loads and page byte writes
`timescale 1ns/1ps
module rxalm_host_model #(
  parameter int WR_GAP = 2
) (
  input  wire logic                i_clk,
  output logic                     o_rd_los,
  output logic                     o_rd_alm,
  output logic                     o_cfg_we,
  output rxalm_pkg::rxalm_chctl_s  o_chctl,
  output rxalm_pkg::rxalm_irqcfg_s o_irqcfg,
  output logic                     o_we,
  output logic [7:0]               o_addr,
  output logic [7:0]               o_data
);
  import rxalm_pkg::*;
  initial begin
    {o_rd_los, o_rd_alm, o_cfg_we, o_we} = 4'h0;
    o_chctl = '0;
    o_irqcfg = '0;
    {o_addr, o_data} = 16'h0000;
  end
  // Serial access reduced to one-cycle strobes, slave side only answers
  task automatic strobe(input int k);
    if (k == 0) o_rd_los = 1'b1;
    else if (k == 1) o_rd_alm = 1'b1;
    else o_cfg_we = 1'b1;
    @(posedge i_clk);
    #1;
    // Drop only the strobe raised here, so a following call may raise another
    if (k == 0) o_rd_los = 1'b0;
    else if (k == 1) o_rd_alm = 1'b0;
    else o_cfg_we = 1'b0;
  endtask : strobe
  task automatic cfg(input rxalm_chctl_s c, input rxalm_irqcfg_s q);
    o_chctl = c;
    o_irqcfg = q;
    strobe(2);
  endtask : cfg
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {o_we, o_addr, o_data} = {1'b1, a, d};
    @(posedge i_clk);
    #1;
    // Released lines show inverted garbage
    {o_we, o_addr, o_data} = {1'b0, ~a, ~d};
    repeat (WR_GAP) @(posedge i_clk);
    #1;
  endtask : wr
endmodule : rxalm_host_model

// [tb/testbench.sv]
// Self-checking bench for the receiver alarm and control block
`timescale 1ns/1ps
module testbench;
  import rxalm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mrst_n = 1'b1, rd_los, rd_alm, cfg_we, we, irq_n;
  logic [2:0] adr = 3'h0, adr_o;
  logic [NCH-1:0] input_signal_lost = '0, los_f, sq, inv;
  logic [NALM-1:0] alm = '0, alm_f;
  logic [NCH*BW_W-1:0] bw = '0;
  logic [7:0] addr, data;
  rxalm_chctl_s chctl, cc;
  rxalm_irqcfg_s irqcfg;
  rxalm_shape_s shp;
  logic [NCH*AMP_W-1:0] e_amp = '0;
  logic [NCH*DEMPH_W-1:0] e_dem = '0;
  int err_total = 0, compares = 0, ch, lo;
  always #5 clk = ~clk;
  rxalm_host_model i_rxalm_host_model (.i_clk(clk), .o_rd_los(rd_los), .o_rd_alm(rd_alm),
    .o_cfg_we(cfg_we), .o_chctl(chctl), .o_irqcfg(irqcfg), .o_we(we), .o_addr(addr),
    .o_data(data));
  rxalm_core i_rxalm_core (.i_clk(clk), .i_rst_n(rst_n), .i_module_rst_n(mrst_n),
    .i_adr_sel(adr), .i_input_signal_lost(input_signal_lost), .i_alarm_cond(alm), .i_rd_los_flags(rd_los),
    .i_rd_alm_flags(rd_alm), .i_cfg_we(cfg_we), .i_chctl(chctl), .i_irqcfg(irqcfg),
    .i_shape_we(we), .i_shape_addr(addr), .i_shape_data(data), .i_bw(bw),
    .o_los_flags(los_f), .o_alm_flags(alm_f), .o_host_irq_n(irq_n), .o_squelch(sq),
    .o_invert(inv), .o_adr_sel(adr_o), .o_shape(shp));
  task automatic check(input logic [119:0] seen, input logic [119:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function automatic void note_wr(input logic [7:0] a, input logic [7:0] d);
    if (a >= AMP_FIRST && a <= AMP_LAST) e_amp[(a - AMP_FIRST) * 8 +: 8] = d;
    else if (a >= DEMPH_FIRST && a <= DEMPH_LAST) e_dem[(a - DEMPH_FIRST) * 8 +: 8] = d;
  endfunction : note_wr
  task automatic conclude();
    $display("Errors %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #300000;
    err_total++;
    conclude();
  end
  initial begin
    logic [7:0] a, d;
    void'($urandom(32'hf6fead6e));
    tick(8);
    rst_n = 1'b1;
    tick(4);
    check({irq_n, los_f, alm_f, sq, inv}, {1'b1, 44'h0});
    check(shp, '0);
    for (int i = 0; i < 24; i++) begin
      a = 8'($urandom_range(241, 226));
      d = (i == 5) ? 8'h00 : 8'($urandom);
      bw = (NCH*BW_W)'($urandom);
      i_rxalm_host_model.wr(a, d);
      note_wr(a, d);
      check(shp, {e_amp, e_dem, bw});
    end
    for (int k = 0; k < 4; k++) begin
      ch = $urandom_range(NCH - 1);
      lo = $urandom_range(NALM - 1);
      cc = {NCH'($urandom), NCH'(0), NCH'($urandom)};
      i_rxalm_host_model.cfg(cc, {k[1] ? 20'hf_ffff : 20'h0_0000, k[0]});
      input_signal_lost[ch] = 1'b1;
      alm[lo] = 1'b1;
      tick(5);
      check({los_f, alm_f}, {NCH'(1) << ch, NALM'(1) << lo});
      check({sq, inv}, {(NCH'(1) << ch) & ~cc.sq_dis, cc.invert});
      check(irq_n, k[1]);
      tick(3);
      check(irq_n, k[1]);
      {input_signal_lost, alm} = '0;
      tick(1);
      check(irq_n, k[1] | k[0]);
      tick(6);
      check({los_f, alm_f}, {NCH'(1) << ch, NALM'(1) << lo});
      i_rxalm_host_model.strobe(0);
      i_rxalm_host_model.strobe(1);
      tick(3);
      check({irq_n, los_f, alm_f}, {1'b1, 20'h0});
      input_signal_lost[ch] = 1'b1;
      tick(5);
      i_rxalm_host_model.strobe(0);
      tick(2);
      check(los_f, NCH'(1) << ch);
      input_signal_lost[ch] = 1'b0;
      tick(3);
      i_rxalm_host_model.strobe(0);
      cc.deact = NCH'($urandom);
      i_rxalm_host_model.cfg(cc, '0);
      adr = 3'($urandom);
      tick(6);
      check({sq, adr_o}, {cc.deact, adr});
    end
    mrst_n = 1'b0;
    tick(6);
    mrst_n = 1'b1;
    tick(4);
    check(shp, {96'h0, bw});
    check({inv, sq}, 24'h0);
    conclude();
  end
endmodule : testbench
